// file: src/smca_top.sv
// Serial management port with indirect configuration word access
`timescale 1ns/1ps
`default_nettype none
module smca_top (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic hardware_reset_pin_n_i,
	// Straps sampled during reset
	input wire logic [1:0] device_select_id_i,
	input wire logic eeprom_attached_i,
	input wire logic eeprom_small_i,
	// Serial management port
	input wire logic mgmt_serial_clock_i,
	input wire logic mgmt_data_i,
	output logic mgmt_data_o,
	output logic mgmt_data_oe_n_o,
	// EEPROM pins observed by the device
	input wire logic eeprom_chip_select_i,
	input wire logic eeprom_serial_clock_i,
	input wire logic eeprom_serial_data_in_i,
	// Device side
	output logic phy_reset_o,
	output logic mgmt_ready_o,
	output logic [smca_pkg::CFG_WORDS*16-1:0] cfg_words_o
);
	typedef struct packed {
		logic [1:0] sck_s;
		logic [1:0] sda_s;
		logic [1:0] rst_s;
		logic [1:0] ecs_s;
		logic [1:0] eck_s;
		logic [1:0] edi_s;
		logic sck_d;
		logic eck_d;
		smca_pkg::smca_state_t st;
		logic [5:0] pre_cnt;
		logic inited;
		logic [4:0] cnt;
		logic [1:0] op;
		logic [9:0] addr_sh;
		logic rd;
		logic match;
		logic [31:0] sh;
		logic drv_oe;
		logic drv_bit;
		logic out_oe;
		logic out_bit;
		logic [5:0] ind_addr;
		logic [15:0] ind_data;
		logic [smca_pkg::CFG_WORDS-1:0][15:0] cfg;
		logic [1:0] sel_id;
		logic ee_att;
		logic ee_small;
		logic [26:0] ee_sh;
		logic [4:0] ee_cnt;
		logic ee_wen;
		logic [7:0] phy_cnt;
		logic phy_rst;
	} smca_regs_t;

	smca_regs_t r;
	smca_regs_t next_r;
	logic rst_all;
	logic sck_rise;
	logic sck_fall;
	logic eck_rise;
	logic sd;
	logic [4:0] ee_hdr;
	logic [31:0] wdata;
	logic [5:0] waddr;
	logic [9:0] a;
	// Top bit of the three-bit command field in register 04
	localparam int CMD_HI = smca_pkg::CMD_POS + 2;

	// Hardware reset pin acts like the system reset once synchronised
	assign rst_all = sys_rst_i | ~r.rst_s[1];
	assign sck_rise = r.sck_s[1] & ~r.sck_d;
	assign sck_fall = ~r.sck_s[1] & r.sck_d;
	assign eck_rise = r.eck_s[1] & ~r.eck_d;
	assign sd = r.sda_s[1];
	// Larger format unless a small part is really attached
	assign ee_hdr = (r.ee_att && r.ee_small) ? smca_pkg::EE_HDR_SMALL
		: smca_pkg::EE_HDR_LARGE;
	assign wdata = {r.sh[30:0], sd};
	assign waddr = wdata[smca_pkg::ADDR_POS +: 6];
	assign a = {r.addr_sh[8:0], sd};

	// Next-state logic for the whole block
	always_comb begin
		next_r = r;
		// Two-flop synchronisers; the first stage feeds only the second
		next_r.sck_s = {r.sck_s[0], mgmt_serial_clock_i};
		next_r.sda_s = {r.sda_s[0], mgmt_data_i};
		next_r.rst_s = {r.rst_s[0], hardware_reset_pin_n_i};
		next_r.ecs_s = {r.ecs_s[0], eeprom_chip_select_i};
		next_r.eck_s = {r.eck_s[0], eeprom_serial_clock_i};
		next_r.edi_s = {r.edi_s[0], eeprom_serial_data_in_i};
		next_r.sck_d = r.sck_s[1];
		next_r.eck_d = r.eck_s[1];
		if (sys_rst_i) begin
			next_r.sck_s = 2'h0;
			next_r.sda_s = 2'h0;
			next_r.rst_s = 2'h0;
			next_r.ecs_s = 2'h0;
			next_r.eck_s = 2'h0;
			next_r.edi_s = 2'h0;
			next_r.sck_d = 1'b0;
			next_r.eck_d = 1'b0;
		end
		if (rst_all) begin
			// Straps caught while reset is held; all words to defaults
			next_r.sel_id = device_select_id_i;
			next_r.ee_att = eeprom_attached_i;
			next_r.ee_small = eeprom_small_i;
			for (int i = 0; i < smca_pkg::CFG_WORDS; i++) begin
				next_r.cfg[i] = smca_pkg::smca_cfg_default(6'(i));
			end
			next_r.st = smca_pkg::ST_PRE;
			next_r.pre_cnt = 6'h00;
			next_r.inited = 1'b0;
			next_r.cnt = 5'h00;
			next_r.op = 2'h0;
			next_r.addr_sh = 10'h000;
			next_r.rd = 1'b0;
			next_r.match = 1'b0;
			next_r.sh = 32'h0000_0000;
			next_r.drv_oe = 1'b0;
			next_r.drv_bit = 1'b0;
			next_r.out_oe = 1'b0;
			next_r.out_bit = 1'b0;
			next_r.ind_addr = 6'h00;
			next_r.ind_data = 16'h0000;
			next_r.ee_sh = 27'h0;
			next_r.ee_cnt = 5'h00;
			next_r.ee_wen = 1'b0;
			next_r.phy_cnt = 8'h00;
			next_r.phy_rst = 1'b1;
		end else begin
			// Frame decoder advances on each management clock rise
			if (sck_rise) begin
				case (r.st)
					smca_pkg::ST_PRE: begin
						if (sd) begin
							next_r.pre_cnt = r.pre_cnt + 6'h01;
							if (r.pre_cnt == smca_pkg::PREAMBLE_BITS - 6'h01) begin
								next_r.st = smca_pkg::ST_IDLE;
								next_r.inited = 1'b1;
							end
						end else begin
							next_r.pre_cnt = 6'h00;
						end
					end
					smca_pkg::ST_IDLE: begin
						// Idle ones are skipped, no preamble needed now
						if (!sd) begin
							next_r.st = smca_pkg::ST_START;
						end
					end
					smca_pkg::ST_START: begin
						next_r.cnt = 5'h00;
						next_r.st = sd ? smca_pkg::ST_OP : smca_pkg::ST_SKIP;
					end
					smca_pkg::ST_OP: begin
						next_r.op = {r.op[0], sd};
						next_r.cnt = r.cnt + 5'h01;
						if (r.cnt == 5'h01) begin
							next_r.cnt = 5'h00;
							if ({r.op[0], sd} == smca_pkg::OP_READ
								|| {r.op[0], sd} == smca_pkg::OP_WRITE) begin
								next_r.st = smca_pkg::ST_ADDR;
							end else begin
								next_r.st = smca_pkg::ST_SKIP;
							end
						end
					end
					smca_pkg::ST_ADDR: begin
						next_r.addr_sh = a;
						next_r.cnt = r.cnt + 5'h01;
						if (r.cnt == 5'h09) begin
							next_r.cnt = 5'h00;
							next_r.st = smca_pkg::ST_TA;
							next_r.rd = (r.op == smca_pkg::OP_READ);
							// Unused bits must be zero for a match
							next_r.match = (a[9:8] == r.sel_id)
								&& (a[7:5] == smca_pkg::UNUSED_ADDR);
							next_r.sh = 32'h0000_0000;
							if (a[4:0] == smca_pkg::MGMT_REG_INDIRECT) begin
								next_r.sh = {10'h000, r.ind_addr, r.ind_data};
							end
							// First turnaround bit: line left to the pull-up
							next_r.drv_oe = 1'b0;
						end
					end
					smca_pkg::ST_TA: begin
						next_r.cnt = r.cnt + 5'h01;
						if (r.cnt == 5'h00) begin
							// Second turnaround bit driven low on reads
							next_r.drv_oe = r.rd && r.match;
							next_r.drv_bit = 1'b0;
						end else begin
							next_r.cnt = 5'h00;
							next_r.st = smca_pkg::ST_DATA;
							next_r.drv_bit = r.sh[31];
						end
					end
					smca_pkg::ST_DATA: begin
						next_r.cnt = r.cnt + 5'h01;
						if (r.rd) begin
							next_r.sh = {r.sh[30:0], 1'b0};
							next_r.drv_bit = r.sh[30];
						end else begin
							next_r.sh = wdata;
						end
						if (r.cnt == 5'h1f) begin
							// Last of 32 bits; release and require an idle bit
							next_r.drv_oe = 1'b0;
							next_r.cnt = 5'h00;
							next_r.st = smca_pkg::ST_SKIP;
							if (!r.rd && r.match
								&& r.addr_sh[4:0] == smca_pkg::MGMT_REG_INDIRECT) begin
								if (wdata[CMD_HI:smca_pkg::CMD_POS] == smca_pkg::CMD_READ) begin
									next_r.ind_addr = waddr;
									next_r.ind_data = (waddr <= smca_pkg::CFG_LAST)
										? r.cfg[waddr] : 16'h0000;
								end else if (wdata[CMD_HI:smca_pkg::CMD_POS]
									== smca_pkg::CMD_WRITE) begin
									next_r.ind_addr = waddr;
									if (waddr <= smca_pkg::CFG_LAST) begin
										next_r.cfg[waddr] = wdata[15:0];
									end else if (waddr == smca_pkg::CFG_SOFT_RST
										&& wdata[15:0] == smca_pkg::SOFT_RST_VALUE) begin
										// PHYs only: straps and words stay as they are
										next_r.phy_cnt = 8'(smca_pkg::PHY_RST_CYC);
									end
								end
							end
						end
					end
					smca_pkg::ST_SKIP: begin
						// A one on the line is the idle bit that ends the gap
						if (sd) begin
							next_r.st = smca_pkg::ST_IDLE;
						end
					end
					default: begin
						next_r.st = smca_pkg::ST_SKIP;
					end
				endcase
			end
			// Line changes on the fall so it is settled by the next rise
			if (sck_fall) begin
				next_r.out_oe = r.drv_oe;
				next_r.out_bit = r.drv_bit;
			end
			// EEPROM instruction watcher; chip select low restarts it
			if (!r.ecs_s[1]) begin
				next_r.ee_cnt = 5'h00;
			end else if (eck_rise) begin
				// A leading zero is not a start bit
				if (r.ee_cnt != 5'h00 || r.edi_s[1]) begin
					next_r.ee_sh = {r.ee_sh[25:0], r.edi_s[1]};
					if (r.ee_cnt != 5'h1f) begin
						next_r.ee_cnt = r.ee_cnt + 5'h01;
					end
				end
				// Start bit sits on top, opcode below it, address top next
				if (r.ee_cnt + 5'h01 == ee_hdr && r.ee_sh[ee_hdr - 5'h04 +: 2]
					== smca_pkg::EE_OP_MISC) begin
					if (r.ee_sh[ee_hdr - 5'h06 +: 2] == smca_pkg::EE_MISC_ENABLE) begin
						next_r.ee_wen = 1'b1;
					end else if (r.ee_sh[ee_hdr - 5'h06 +: 2]
						== smca_pkg::EE_MISC_DISABLE) begin
						next_r.ee_wen = 1'b0;
					end
				end
				if (r.ee_cnt + 5'h01 == ee_hdr + smca_pkg::EE_DATA_BITS && r.ee_wen
					&& r.ee_sh[ee_hdr + 5'h0c +: 2] == smca_pkg::EE_OP_WRITE
					&& r.ee_sh[20:15] <= smca_pkg::CFG_LAST) begin
					next_r.cfg[r.ee_sh[20:15]] = {r.ee_sh[14:0], r.edi_s[1]};
				end
			end
			// Soft reset pulse length counter
			if (r.phy_cnt != 8'h00 && next_r.phy_cnt == r.phy_cnt) begin
				next_r.phy_cnt = r.phy_cnt - 8'h01;
			end
			next_r.phy_rst = (r.phy_cnt != 8'h00);
		end
	end

	// State register with synchronous reset folded into next_r
	always_ff @(posedge sys_clk_i) begin
		r <= next_r;
	end

	// Outputs straight from the state register
	assign mgmt_data_o = r.out_bit;
	assign mgmt_data_oe_n_o = ~r.out_oe;
	assign phy_reset_o = r.phy_rst;
	assign mgmt_ready_o = r.inited;
	assign cfg_words_o = r.cfg;
endmodule
`default_nettype wire

// file: common/smca_pkg.sv
// Constants and types for the serial management and configuration access block
package smca_pkg;
	localparam int SYS_CLK_HZ = 20000000;
	localparam int MAX_SDC_HZ = 25000000;
	localparam logic [5:0] PREAMBLE_BITS = 6'h23;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [2:0] UNUSED_ADDR = 3'h0;
	localparam logic [4:0] MGMT_REG_INDIRECT = 5'h04;
	localparam logic [2:0] CMD_WRITE = 3'h1;
	localparam logic [2:0] CMD_READ = 3'h2;
	localparam int CMD_POS = 29;
	localparam int ADDR_POS = 16;
	localparam int CFG_WORDS = 61;
	localparam logic [5:0] CFG_LAST = 6'h3c;
	localparam logic [5:0] CFG_SOFT_RST = 6'h3f;
	localparam logic [15:0] SOFT_RST_VALUE = 16'h00ff;
	// EEPROM instruction fields
	localparam logic [1:0] EE_OP_WRITE = 2'h1;
	localparam logic [1:0] EE_OP_MISC = 2'h0;
	localparam logic [1:0] EE_MISC_ENABLE = 2'h3;
	localparam logic [1:0] EE_MISC_DISABLE = 2'h0;
	localparam logic [4:0] EE_HDR_LARGE = 5'h0b;
	localparam logic [4:0] EE_HDR_SMALL = 5'h09;
	localparam logic [4:0] EE_DATA_BITS = 5'h10;
	// PHY reset pulse after a soft reset
	localparam int PHY_RST_NS = 1000;
	localparam int PHY_RST_CYC = (PHY_RST_NS * (SYS_CLK_HZ / 1000000) + 999) / 1000;
	localparam logic [15:0] SIGNATURE = 16'h5a5a; // Arbitrary value

	typedef enum logic [2:0] {
		ST_PRE, ST_IDLE, ST_START, ST_OP, ST_ADDR, ST_TA, ST_DATA, ST_SKIP
	} smca_state_t;

	// Default contents of each configuration word
	function automatic logic [15:0] smca_cfg_default(input logic [5:0] idx);
		logic [15:0] v;
		v = 16'h0000;
		case (idx)
			6'h00: v = SIGNATURE;
			6'h01, 6'h02, 6'h03: v = 16'h820f;
			6'h04: v = 16'hf0f0;
			6'h05: v = 16'h00c0;
			6'h06: v = 16'h82e8;
			6'h07: v = 16'h1480;
			6'h08: v = 16'h0777;
			6'h23, 6'h25, 6'h27: v = 16'h0001;
			default: begin
				if (idx >= 6'h29 && idx <= 6'h38) begin
					v = idx[0] ? 16'hf000 : 16'h00ff;
				end
			end
		endcase
		return v;
	endfunction
endpackage

// file: tb/smca_sva.sv
// Port checks for the serial management block
`timescale 1ns/1ps
`default_nettype none
module smca_sva (
	// Clock and resets
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic hardware_reset_pin_n_i,
	// Link and device outputs
	input wire logic mgmt_serial_clock_i,
	input wire logic mgmt_data_o,
	input wire logic mgmt_data_oe_n_o,
	input wire logic phy_reset_o,
	input wire logic mgmt_ready_o,
	input wire logic [smca_pkg::CFG_WORDS*16-1:0] cfg_words_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i || !hardware_reset_pin_n_i);
	logic [9:0] drive_cnt;
	// Length of one drive period; a read holds the line 33 bit times
	always_ff @(posedge sys_clk_i) begin
		if (mgmt_data_oe_n_o) drive_cnt <= 10'h000;
		else drive_cnt <= drive_cnt + 10'h001;
	end
	reset_state_a: assert property (disable iff (!hardware_reset_pin_n_i)
		sys_rst_i |=> mgmt_data_oe_n_o && phy_reset_o && !mgmt_ready_o)
		else $error("outputs not at reset level");
	cfg_default_a: assert property (disable iff (!hardware_reset_pin_n_i)
		sys_rst_i |=> cfg_words_o[15:0] == smca_pkg::SIGNATURE)
		else $error("word 0 not at default");
	quiet_early_a: assert property (!mgmt_ready_o |-> mgmt_data_oe_n_o)
		else $error("line driven before preamble");
	ready_holds_a: assert property (mgmt_ready_o |=> mgmt_ready_o)
		else $error("ready dropped");
	ta_zero_a: assert property ($fell(mgmt_data_oe_n_o) |-> !mgmt_data_o)
		else $error("turnaround bit not zero");
	read_len_a: assert property ($rose(mgmt_data_oe_n_o) |->
		drive_cnt >= 10'd262 && drive_cnt <= 10'd266)
		else $error("read data length wrong");
	bit_stable_a: assert property ($rose(mgmt_serial_clock_i) &&
		!mgmt_data_oe_n_o |-> ##1 $stable(mgmt_data_o)[*4])
		else $error("read bit moved near rising edge");
	phy_pulse_a: assert property ($rose(phy_reset_o) |->
		phy_reset_o[*8] ##12 phy_reset_o ##1 !phy_reset_o)
		else $error("phy reset pulse length wrong");
endmodule
`default_nettype wire

// file: tb/smca_ctrl_model.sv
// Management controller model driving the serial link
`timescale 1ns/1ps
`default_nettype none
module smca_ctrl_model (
	// System clock and resolved line
	input wire logic sys_clk_i,
	input wire logic line_i,
	// Link outputs
	output logic clk_o,
	output logic d_o,
	output logic drive_o
);
	// Link idles with clock still and line released
	initial begin
		clk_o = 1'b0;
		d_o = 1'b0;
		drive_o = 1'b0;
	end
	// One 400 ns bit; line taken late in the high phase, clear of changes
	task automatic bit_t(input logic drv, input logic v, output logic s);
		clk_o <= 1'b0;
		drive_o <= drv;
		d_o <= v;
		repeat (4) @(posedge sys_clk_i);
		clk_o <= 1'b1;
		repeat (4) @(posedge sys_clk_i);
		s = line_i;
	endtask
	// Whole frame MSB first; reads release the line from the first turnaround
	task automatic frame(input int pre, input logic [1:0] st,
		input logic [1:0] op, input logic [1:0] sel, input logic [4:0] rg,
		input logic [31:0] wd, output logic [31:0] rd);
		logic [47:0] f;
		logic s;
		f = {st, op, sel, 3'h0, rg, 2'h2, wd};
		rd = 32'h0;
		for (int i = 0; i < pre; i++) bit_t(1'b1, 1'b1, s);
		for (int i = 47; i >= 0; i--) begin
			bit_t(!(op == smca_pkg::OP_READ && i < 34), f[i], s);
			if (i < 32) rd[i] = s;
		end
		bit_t(1'b0, 1'b1, s);
	endtask
endmodule
`default_nettype wire

// file: tb/smca_tb_top.sv
// Self-checking bench for the serial management block
`timescale 1ns/1ps
`default_nettype none
module smca_tb_top;
	logic sys_clk_i;
	logic sys_rst_i;
	logic hw_rst_n;
	logic ee_cs;
	logic ee_ck;
	logic ee_di;
	logic dev_d;
	logic dev_oe_n;
	logic phy_rst;
	logic ready;
	logic [smca_pkg::CFG_WORDS*16-1:0] words;
	logic mclk;
	logic mdrv;
	logic md;
	logic mgmt_line;
	logic phy_seen;
	logic [31:0] rd;
	logic [15:0] dat;
	logic [5:0] addr_tab [2];
	int num_errors;
	int total_checks;
	int cycles;
	// Pulled-up line: device first, then controller, else high
	assign mgmt_line = !dev_oe_n ? dev_d : (mdrv ? md : 1'b1);
	smca_top uut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
		.hardware_reset_pin_n_i(hw_rst_n), .device_select_id_i(2'h0),
		.eeprom_attached_i(1'b0), .eeprom_small_i(1'b0),
		.mgmt_serial_clock_i(mclk), .mgmt_data_i(mgmt_line),
		.mgmt_data_o(dev_d), .mgmt_data_oe_n_o(dev_oe_n),
		.eeprom_chip_select_i(ee_cs), .eeprom_serial_clock_i(ee_ck),
		.eeprom_serial_data_in_i(ee_di), .phy_reset_o(phy_rst),
		.mgmt_ready_o(ready), .cfg_words_o(words));
	smca_ctrl_model ctl (.sys_clk_i(sys_clk_i), .line_i(mgmt_line),
		.clk_o(mclk), .d_o(md), .drive_o(mdrv));
	// 20 MHz clock
	always #25 sys_clk_i = ~sys_clk_i;
	// Watchdog and sticky record of the short phy pulse
	always @(posedge sys_clk_i) begin
		cycles <= cycles + 1;
		if (phy_rst && !sys_rst_i && hw_rst_n) phy_seen <= 1'b1;
		if (cycles == 40000) begin
			num_errors++;
			complete_run();
		end
	end
	task automatic chk(input string nm, input logic [31:0] exp,
		input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wchk(input string nm, input int idx, input logic [15:0] e);
		chk(nm, {16'h0, e}, {16'h0, words[16*idx +: 16]});
	endtask
	// Frames without preamble, own select, valid start
	task automatic wr(input logic [31:0] wd);
		ctl.frame(0, 2'h1, smca_pkg::OP_WRITE, 2'h0, 5'h04, wd, rd);
	endtask
	task automatic rdreg(input logic [4:0] rg);
		ctl.frame(0, 2'h1, smca_pkg::OP_READ, 2'h0, rg, 32'h0, rd);
	endtask
	// EEPROM instruction, n bits MSB first, chip select framing it
	task automatic ee(input logic [26:0] v, input int n);
		ee_cs <= 1'b1;
		for (int i = n - 1; i >= 0; i--) begin
			ee_di <= v[i];
			ee_ck <= 1'b0;
			repeat (4) @(posedge sys_clk_i);
			ee_ck <= 1'b1;
			repeat (4) @(posedge sys_clk_i);
		end
		ee_ck <= 1'b0;
		ee_cs <= 1'b0;
		repeat (4) @(posedge sys_clk_i);
	endtask
	task automatic complete_run();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		sys_clk_i = 1'b0;
		sys_rst_i = 1'b1;
		hw_rst_n = 1'b1;
		{ee_cs, ee_ck, ee_di} = 3'h0;
		phy_seen = 1'b0;
		cycles = 0;
		num_errors = 0;
		total_checks = 0;
		addr_tab = '{6'h02, 6'h3c};
		repeat (16) @(posedge sys_clk_i);
		sys_rst_i <= 1'b0;
		repeat (8) @(posedge sys_clk_i);
		wchk("word 1 default", 1, 16'h820f);
		rdreg(5'h04);
		chk("read before preamble", 32'hffffffff, rd);
		ctl.frame(35, 2'h1, smca_pkg::OP_WRITE, 2'h0, 5'h04,
			{3'h1, 7'h0, 6'h01, 16'h1234}, rd);
		chk("ready", 32'h1, {31'h0, ready});
		wchk("word 1 written", 1, 16'h1234);
		ctl.frame(0, 2'h1, 2'h3, 2'h0, 5'h04, {3'h1, 7'h0, 6'h03, 16'h0}, rd);
		ctl.frame(0, 2'h0, smca_pkg::OP_WRITE, 2'h0, 5'h04,
			{3'h1, 7'h0, 6'h03, 16'h0}, rd);
		wchk("word 3 after bad frames", 3, 16'h820f);
		foreach (addr_tab[k]) begin
			dat = {addr_tab[k], 10'h2a5};
			wr({3'h1, 7'h0, addr_tab[k], dat});
			wr({3'h2, 7'h0, addr_tab[k], 16'h0});
			rdreg(5'h04);
			chk("indirect read", {10'h0, addr_tab[k], dat}, rd);
		end
		ctl.frame(0, 2'h1, smca_pkg::OP_READ, 2'h2, 5'h04, 32'h0, rd);
		chk("foreign select", 32'hffffffff, rd);
		rdreg(5'h05);
		chk("other register", 32'h0, rd);
		phy_seen <= 1'b0;
		wr({3'h1, 7'h0, 6'h3f, 16'h00ff});
		chk("phy pulse", 32'h1, {31'h0, phy_seen});
		wchk("word 1 kept", 1, 16'h1234);
		ee({16'h0, 3'h5, 8'h06}, 11);
		ee({1'b1, 2'h1, 8'h06, 16'hbeef}, 27);
		wchk("eeprom write locked", 6, 16'h82e8);
		ee({16'h0, 3'h4, 8'hc0}, 11);
		ee({1'b1, 2'h1, 8'h05, 16'hbeef}, 27);
		wchk("eeprom write", 5, 16'hbeef);
		hw_rst_n <= 1'b0;
		repeat (10) @(posedge sys_clk_i);
		hw_rst_n <= 1'b1;
		repeat (8) @(posedge sys_clk_i);
		wchk("word 1 after pin reset", 1, 16'h820f);
		chk("ready after pin reset", 32'h0, {31'h0, ready});
		complete_run();
	end
endmodule
bind smca_top smca_sva chk_i (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
	.hardware_reset_pin_n_i(hardware_reset_pin_n_i),
	.mgmt_serial_clock_i(mgmt_serial_clock_i), .mgmt_data_o(mgmt_data_o),
	.mgmt_data_oe_n_o(mgmt_data_oe_n_o), .phy_reset_o(phy_reset_o),
	.mgmt_ready_o(mgmt_ready_o), .cfg_words_o(cfg_words_o));
`default_nettype wire
